//--- inc/odl_defs.svh
// Constants for the octal DAC serial load control block.
// Assumes inclusion by bare name from design files.
`ifndef ODL_DEFS_SVH
`define ODL_DEFS_SVH
`define ODL_WORD_BITS    12
`define ODL_ADDR_BITS    4
`define ODL_CODE_BITS    8
`define ODL_NUM_CHAN     8
`define ODL_MIDSCALE     8'h80
`define ODL_ADDR_LSB     8
`define ODL_ADDR_MSB     11
`define ODL_CODE_MSB     7
`define ODL_FIRST_ADDR   4'h1
`define ODL_LAST_ADDR    4'h8
`endif

//--- inc/odl_pkg.sv
// Types for the octal DAC serial load control block.
// Assumes odl_defs.svh is on the include path.
`include "odl_defs.svh"
package odl_pkg;
   typedef logic [`ODL_CODE_BITS-1:0] odl_code_type;
   typedef logic [`ODL_WORD_BITS-1:0] odl_word_type;
   typedef logic [`ODL_ADDR_BITS-1:0] odl_addr_type;
endpackage

//--- logic/odl_sync.sv
// Two-flop synchroniser for one pin input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module odl_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Level in and out
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   // First stage is read only by the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- logic/odl_serial_load.sv
// Serial load control of an eight-channel DAC: shift register, decode, holding registers.
// Assumes pins arrive asynchronous to core_clk; the serial clock is sampled, not used as a clock.
// Operation
// - Rising serial clock with strobe low, preset high shifts serial_in in.
// - serial_out shows the bit entered twelve serial clock edges earlier.
// - Preset low forces all holding registers to 80 hex.
// - Strobe rising with clock low copies data into addressed channel.
// - Twelve-bit word, MSB first: four address bits then eight data bits.
// - Addresses 1 to 8 select channels A to H; others are no-ops.
`timescale 1ns/1ps
`default_nettype none
`include "odl_defs.svh"
module odl_serial_load (
   // Clock, reset, enable
   input  wire logic                                   core_clk,
   input  wire logic                                   rst,
   input  wire logic                                   clk_en,
   // Serial pins
   input  wire logic                                   serial_clk,
   input  wire logic                                   serial_in,
   input  wire logic                                   load_strobe,
   input  wire logic                                   preset_n,
   output logic                                        serial_out,
   // Channel codes, channel A at index 0
   output odl_pkg::odl_code_type [`ODL_NUM_CHAN-1:0]   chan_code
);
   import odl_pkg::*;

   logic         sclk_s;
   logic         sdi_s;
   logic         load_s;
   logic         preset_n_s;
   logic         sclk_prev_q;
   logic         load_prev_q;
   odl_word_type shift_q;
   logic         shift_ev;
   logic         load_ev;
   odl_addr_type addr;

   // All pins cross into core_clk before any logic looks at them.
   // Cost is two cycles of latency on every pin, far below one serial bit.
   // Serial clock; its idle level is low, matching the synchroniser reset
   odl_sync u_sync_sclk (
      .clk (core_clk),
      .rst (rst),
      .ce  (clk_en),
      .d   (serial_clk),
      .q   (sclk_s)
   );

   // Serial data; stable around the rising clock by the host's timing
   odl_sync u_sync_sdi (
      .clk (core_clk),
      .rst (rst),
      .ce  (clk_en),
      .d   (serial_in),
      .q   (sdi_s)
   );

   // Load strobe; resets low so no false rising edge follows reset
   odl_sync u_sync_load (
      .clk (core_clk),
      .rst (rst),
      .ce  (clk_en),
      .d   (load_strobe),
      .q   (load_s)
   );

   // Preset; resets low, so codes are held at midscale until it settles
   odl_sync u_sync_pre (
      .clk (core_clk),
      .rst (rst),
      .ce  (clk_en),
      .d   (preset_n),
      .q   (preset_n_s)
   );

   // Edge history of the synchronised clock and strobe.
   // Both start low, the idle level of their pins, so reset makes no edge.
   // Limitation: pulses shorter than a few core_clk cycles are missed.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
         load_prev_q <= 1'b0;
      end else if (clk_en) begin
         sclk_prev_q <= sclk_s;
         load_prev_q <= load_s;
      end
   end

   // Edge events are single-cycle pulses in the core_clk domain.
   // Shift only on a rising serial clock with strobe low and preset released
   assign shift_ev = sclk_s & ~sclk_prev_q & ~load_s & preset_n_s;
   // Load on the strobe's rising edge while the serial clock is low
   assign load_ev  = load_s & ~load_prev_q & ~sclk_s & preset_n_s;
   assign addr     = shift_q[`ODL_ADDR_MSB:`ODL_ADDR_LSB];

   // Shift register, MSB entered first so the address ends up on top
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shift_q <= '0;
      end else if (clk_en && shift_ev) begin
         shift_q <= {shift_q[`ODL_WORD_BITS-2:0], sdi_s};
      end
   end

   // Last stage echoed for cascading; it lags serial_in by twelve edges
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         serial_out <= 1'b0;
      end else if (clk_en && shift_ev) begin
         serial_out <= shift_q[`ODL_WORD_BITS-2];
      end
   end

   // Holding registers; preset wins over everything, no-op addresses match nothing.
   // Load is edge-triggered, so releasing preset with the strobe high
   // does not reload a channel; this is the safe reading of the host rule.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `ODL_NUM_CHAN; i++) begin
            chan_code[i] <= `ODL_MIDSCALE;
         end
      end else if (clk_en) begin
         for (int i = 0; i < `ODL_NUM_CHAN; i++) begin
            if (!preset_n_s) begin
               chan_code[i] <= `ODL_MIDSCALE;
            end else if (load_ev && addr == `ODL_FIRST_ADDR + odl_addr_type'(i)) begin
               chan_code[i] <= shift_q[`ODL_CODE_MSB:0];
            end
         end
      end
   end
   // Otherwise every register keeps its code

   // Checks
   // The echo check needs twelve shifts of history first, so count
   // accepted shifts and saturate; the count only gates an assertion and a cover.
   int unsigned sh_cnt;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sh_cnt <= 0;
      end else if (clk_en && shift_ev && sh_cnt < 100) begin
         sh_cnt <= sh_cnt + 1;
      end
   end

   a_shift_moves_in: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && shift_ev |=> shift_q[0] == $past(sdi_s))
      else $error("shift register missed serial input");
   a_shift_holds: assert property (@(posedge core_clk) disable iff (rst)
      !(clk_en && shift_ev) |=> $stable(shift_q))
      else $error("shift register changed without shift");
   a_sdo_delay: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && shift_ev && sh_cnt >= 12 |=> serial_out == $past(shift_q[`ODL_WORD_BITS-2]))
      else $error("serial output not twelve edges late");
   a_preset_mid: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !preset_n_s |=> chan_code[0] == `ODL_MIDSCALE && chan_code[7] == `ODL_MIDSCALE)
      else $error("preset did not force midscale");
   a_load_chan: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && load_ev && addr == `ODL_FIRST_ADDR |=> chan_code[0] == $past(shift_q[`ODL_CODE_MSB:0]))
      else $error("channel A not loaded");
   a_noop_addr: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && preset_n_s && (addr == 4'h0 || addr > `ODL_LAST_ADDR) |=> $stable(chan_code))
      else $error("no-op address changed a channel");
   a_load_last: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && load_ev && addr == `ODL_LAST_ADDR |=> chan_code[7] == $past(shift_q[`ODL_CODE_MSB:0]))
      else $error("channel H not loaded");
   a_idle_hold: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && preset_n_s && !load_ev ##1 preset_n_s |-> $stable(chan_code))
      else $error("holding registers changed while idle");
   a_no_load_clk: assert property (@(posedge core_clk) disable iff (rst)
      load_ev |-> !shift_ev)
      else $error("load and shift together");
   a_sdo_holds: assert property (@(posedge core_clk) disable iff (rst)
      !(clk_en && shift_ev) |=> $stable(serial_out))
      else $error("serial output moved without shift");
   a_preset_no_shift: assert property (@(posedge core_clk) disable iff (rst)
      !preset_n_s |=> $stable(shift_q))
      else $error("shift register moved during preset");
   a_strobe_no_shift: assert property (@(posedge core_clk) disable iff (rst)
      load_s |=> $stable(shift_q))
      else $error("shift register moved with strobe high");
   a_clk_high_no_load: assert property (@(posedge core_clk) disable iff (rst)
      sclk_s && preset_n_s |=> $stable(chan_code))
      else $error("channel loaded with serial clock high");

   // Per-channel checks, one set for each holding register
   for (genvar g = 0; g < `ODL_NUM_CHAN; g++) begin : g_chan_chk
      a_load_each: assert property (@(posedge core_clk) disable iff (rst)
         clk_en && load_ev && addr == `ODL_FIRST_ADDR + odl_addr_type'(g)
         |=> chan_code[g] == $past(shift_q[`ODL_CODE_MSB:0]))
         else $error("addressed channel not loaded");
      a_preset_each: assert property (@(posedge core_clk) disable iff (rst)
         clk_en && !preset_n_s |=> chan_code[g] == `ODL_MIDSCALE)
         else $error("channel not at midscale under preset");
      a_other_hold: assert property (@(posedge core_clk) disable iff (rst)
         clk_en && preset_n_s && addr != `ODL_FIRST_ADDR + odl_addr_type'(g)
         |=> $stable(chan_code[g]))
         else $error("channel changed for another address");
   end

   // Main scenarios worth seeing at least once

   c_shift: cover property (@(posedge core_clk) disable iff (rst) shift_ev);
   c_load: cover property (@(posedge core_clk) disable iff (rst) load_ev && addr == `ODL_LAST_ADDR);
   c_preset: cover property (@(posedge core_clk) disable iff (rst) !preset_n_s ##1 preset_n_s);
   c_noop: cover property (@(posedge core_clk) disable iff (rst) load_ev && addr == 4'h0);
   c_echo: cover property (@(posedge core_clk) disable iff (rst) shift_ev && sh_cnt >= 12);
endmodule
`default_nettype wire

//--- bench/odl_host.sv
// Host model driving the serial clock, data, load strobe and preset pins.
// Assumes core_clk from the bench; every pin changes at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module odl_host (
   // Timing reference
   input  wire logic core_clk,
   // Pins toward the block
   output logic      serial_clk,
   output logic      serial_in,
   output logic      load_strobe,
   output logic      preset_n
);
   import odl_pkg::*;
   // Link clock stands still low between frames
   initial begin
      serial_clk = 1'b0;
      serial_in = 1'b0;
      load_strobe = 1'b0;
      preset_n = 1'b1;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // One bit per 160 ns; data inverted once its hold has run out
   task automatic send_bit(input logic b);
      serial_in = b;
      wait_cyc(8);
      serial_clk = 1'b1;
      wait_cyc(16);
      serial_clk = 1'b0;
      wait_cyc(8);
      serial_in = ~b;
   endtask
   task automatic send_word(input odl_word_type w);
      for (int i = 11; i >= 0; i--) send_bit(w[i]);
   endtask
   // Strobe only with clock low, no clock edge while high
   task automatic load();
      load_strobe = 1'b1;
      wait_cyc(8);
      load_strobe = 1'b0;
      wait_cyc(8);
   endtask
   // Strobe is always low here, so release never reloads
   task automatic set_preset(input logic v);
      preset_n = v;
      wait_cyc(8);
   endtask
endmodule
`default_nettype wire

//--- bench/test_odl_serial_load.sv
// Bench for the serial load control block with the host model on its pins.
// Assumes odl_pkg compiled first and odl_defs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "odl_defs.svh"
module test_odl_serial_load;
   import odl_pkg::*;
   logic                             core_clk, rst, serial_clk, serial_in, load_strobe, preset_n, serial_out;
   odl_code_type [`ODL_NUM_CHAN-1:0] chan_code;
   odl_code_type                     exp_code [`ODL_NUM_CHAN];
   int                               n_fail = 0, n_compared = 0, cyc = 0;
   odl_serial_load odl_serial_load_i (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .serial_clk(serial_clk),
      .serial_in(serial_in), .load_strobe(load_strobe), .preset_n(preset_n), .serial_out(serial_out),
      .chan_code(chan_code));
   odl_host odl_host_i (.core_clk(core_clk), .serial_clk(serial_clk), .serial_in(serial_in),
      .load_strobe(load_strobe), .preset_n(preset_n));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Watchdog, well above the roughly 7.6k cycles the tests take
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_all();
      for (int c = 0; c < 8; c++) check("chan_code", {4'h0, chan_code[c]}, {4'h0, exp_code[c]});
   endtask
   // Word plus strobe; only addresses 1..8 touch the table
   task automatic write_word(input odl_word_type w);
      odl_host_i.send_word(w);
      odl_host_i.load();
      if (preset_n && w[11:8] >= `ODL_FIRST_ADDR && w[11:8] <= `ODL_LAST_ADDR)
         exp_code[w[11:8] - 1] = w[7:0];
      check_all();
   endtask
   task automatic test_reset();
      foreach (exp_code[c]) exp_code[c] = `ODL_MIDSCALE;
      check_all();
      check("serial_out", {11'h0, serial_out}, 12'h0);
      $display("test_reset done");
   endtask
   task automatic test_decode();
      for (int a = 1; a <= 8; a++) write_word({a[3:0], 8'h1f * a[7:0]});
      for (int a = 0; a < 16; a++) if (a == 0 || a > 8) write_word({a[3:0], 8'h3c});
      $display("test_decode done");
   endtask
   // Old word must emerge MSB first while the next one enters
   task automatic test_echo();
      odl_word_type a = 12'h5a3;
      odl_word_type b = 12'h3c6;
      odl_host_i.send_word(a);
      for (int k = 11; k >= 0; k--) begin
         check("serial_out", {11'h0, serial_out}, {11'h0, a[k]});
         odl_host_i.send_bit(b[k]);
      end
      odl_host_i.load();
      exp_code[2] = 8'hc6;
      check_all();
      $display("test_echo done");
   endtask
   // Traffic during preset is ignored, so the old word is reloaded after
   task automatic test_preset();
      odl_host_i.set_preset(1'b0);
      foreach (exp_code[c]) exp_code[c] = `ODL_MIDSCALE;
      check_all();
      write_word(12'h1ff);
      odl_host_i.set_preset(1'b1);
      check_all();
      odl_host_i.load();
      exp_code[2] = 8'hc6;
      check_all();
      $display("test_preset done");
   endtask
   task automatic complete_run();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(negedge core_clk);
      test_reset();
      test_decode();
      test_echo();
      test_preset();
      complete_run();
   end
endmodule
`default_nettype wire
